// ==== hw/clpr_defs.svh ====
// Register offsets, field layout and reset values of the launch and phase bank.
`ifndef CLPR_DEFS_SVH
`define CLPR_DEFS_SVH

`define CLPR_ADDR_W          4
`define CLPR_OFS_LAUNCH_ARG  4'h0
`define CLPR_OFS_PHASE_A     4'h1
`define CLPR_OFS_PHASE_B     4'h2
`define CLPR_OFS_FREQ_A      4'h3
`define CLPR_OFS_FREQ_B      4'h4
`define CLPR_OFS_MODE_A      4'h5
`define CLPR_OFS_MODE_B      4'h6
`define CLPR_LAUNCH_W        16
`define CLPR_LAUNCH_KEEP     16'hFFFC
`define CLPR_LAUNCH_RST      16'h0000
`define CLPR_PHASE_W         32
`define CLPR_PHASE_RST       32'h00000000
`define CLPR_FREQ_RST        32'h00000000
`define CLPR_MODE_W          3
`define CLPR_MODE_RST        3'h0

`endif

// ==== hw/clpr_pkg.sv ====
// Types shared by the launch-argument and phase accumulator bank.
package clpr_pkg;

	// Accumulation source selected by a counter's mode field.
	typedef enum logic [2:0] {
		CLPR_MODE_HOLD,
		CLPR_MODE_EVERY_CLK,
		CLPR_MODE_PRI_HIGH,
		CLPR_MODE_PRI_RISE,
		CLPR_MODE_PRI_FALL,
		CLPR_MODE_PRI_AND_SEC,
		CLPR_MODE_PRI_OR_SEC
	} clpr_mode_type;

endpackage : clpr_pkg

// ==== hw/clpr_pin_sync.sv ====
// Two-flop synchroniser for the counter input pins.
module clpr_pin_sync
	import clpr_pkg::*;
(
	input  wire logic       REF_CLK,
	input  wire logic       RST_B,
	input  wire logic [1:0] PIN_IN,
	output logic      [1:0] PIN_SYNC
);

	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
	} clpr_sync_state_type;

	clpr_sync_state_type st_reg;
	clpr_sync_state_type st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.meta = PIN_IN;
		st_next.sync = st_reg.meta;
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign PIN_SYNC = st_reg.sync;

endmodule : clpr_pin_sync

// ==== hw/clpr_phase_ctr.sv ====
// One counter module: mode decode and phase accumulation.
`include "clpr_defs.svh"
module clpr_phase_ctr
	import clpr_pkg::*;
(
	input  wire logic                     REF_CLK,
	input  wire logic                     RST_B,
	input  wire logic [`CLPR_MODE_W-1:0]  MODE,
	input  wire logic [`CLPR_PHASE_W-1:0] FREQ,
	input  wire logic                     PRI_PIN,
	input  wire logic                     SEC_PIN,
	input  wire logic                     WR_EN,
	input  wire logic [`CLPR_PHASE_W-1:0] WR_DATA,
	output logic      [`CLPR_PHASE_W-1:0] PHASE
);

	typedef struct packed {
		logic [`CLPR_PHASE_W-1:0] phase;
		logic                     pri_last;
	} clpr_ctr_state_type;

	clpr_ctr_state_type st_reg;
	clpr_ctr_state_type st_next;
	logic               add_en;

	always_comb begin
		case (clpr_mode_type'(MODE))
			CLPR_MODE_EVERY_CLK:   add_en = 1'b1;
			CLPR_MODE_PRI_HIGH:    add_en = PRI_PIN;
			CLPR_MODE_PRI_RISE:    add_en = PRI_PIN & ~st_reg.pri_last;
			CLPR_MODE_PRI_FALL:    add_en = ~PRI_PIN & st_reg.pri_last;
			CLPR_MODE_PRI_AND_SEC: add_en = PRI_PIN & SEC_PIN;
			CLPR_MODE_PRI_OR_SEC:  add_en = PRI_PIN | SEC_PIN;
			default:               add_en = 1'b0;
		endcase
	end

	always_comb begin
		st_next          = st_reg;
		st_next.pri_last = PRI_PIN;
		if (WR_EN) begin
			// A direct write discards any accumulation due this cycle.
			st_next.phase = WR_DATA;
		end else if (add_en) begin
			st_next.phase = st_reg.phase + FREQ;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign PHASE = st_reg.phase;

endmodule : clpr_phase_ctr

// ==== hw/clpr_core_regs.sv ====
// Per-core launch-argument register and the two counter phase registers.
//
// Operation
// - Launch loads launch argument from command field.
// - Launch argument keeps 14 bits, low two zero.
// - Launch argument is read-only to instructions.
// - Two identical counters A and B per core.
// - Phase registers readable and writable like others.
// - Phase may add frequency every system clock.
// - Mode selects hold or pin/clock-paced accumulation.
// - Direct phase write overrides same-cycle accumulation.
`include "clpr_defs.svh"
module clpr_core_regs
	import clpr_pkg::*;
(
	input  wire logic                     REF_CLK,
	input  wire logic                     RST_B,
	input  wire logic [`CLPR_ADDR_W-1:0]  ADDR,
	input  wire logic [31:0]              WDATA,
	input  wire logic                     WR,
	input  wire logic                     RD,
	output logic      [31:0]              RDATA,
	input  wire logic                     LAUNCH,
	input  wire logic [`CLPR_LAUNCH_W-1:0] LAUNCH_PARAM,
	input  wire logic [1:0]               PIN_A,
	input  wire logic [1:0]               PIN_B
);

	typedef struct packed {
		logic [`CLPR_LAUNCH_W-1:0] launch_arg;
		logic [31:0]               freq_a;
		logic [31:0]               freq_b;
		logic [`CLPR_MODE_W-1:0]   mode_a;
		logic [`CLPR_MODE_W-1:0]   mode_b;
		logic [31:0]               rdata;
	} clpr_core_state_type;

	// One flag per register index; write and read paths share this decode.
	typedef struct packed {
		logic launch_arg;
		logic phase_a;
		logic phase_b;
		logic freq_a;
		logic freq_b;
		logic mode_a;
		logic mode_b;
	} clpr_sel_type;

	clpr_core_state_type     st_reg;
	clpr_core_state_type     st_next;
	clpr_sel_type            sel;
	logic [1:0]              ctr_pins  [2];
	logic [`CLPR_MODE_W-1:0] ctr_mode  [2];
	logic [31:0]             ctr_freq  [2];
	logic                    ctr_wr    [2];
	logic [31:0]             ctr_phase [2];

	////////////////////////////////////////////////////////////////////////

	// Unmapped indices leave every flag low, so they read back as zero.
	always_comb begin
		sel = '0;
		if (ADDR == `CLPR_OFS_LAUNCH_ARG) begin
			sel.launch_arg = 1'b1;
		end else if (ADDR == `CLPR_OFS_PHASE_A) begin
			sel.phase_a = 1'b1;
		end else if (ADDR == `CLPR_OFS_PHASE_B) begin
			sel.phase_b = 1'b1;
		end else if (ADDR == `CLPR_OFS_FREQ_A) begin
			sel.freq_a = 1'b1;
		end else if (ADDR == `CLPR_OFS_FREQ_B) begin
			sel.freq_b = 1'b1;
		end else if (ADDR == `CLPR_OFS_MODE_A) begin
			sel.mode_a = 1'b1;
		end else if (ADDR == `CLPR_OFS_MODE_B) begin
			sel.mode_b = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////

	assign ctr_pins[0] = PIN_A;
	assign ctr_pins[1] = PIN_B;
	assign ctr_mode[0] = st_reg.mode_a;
	assign ctr_mode[1] = st_reg.mode_b;
	assign ctr_freq[0] = st_reg.freq_a;
	assign ctr_freq[1] = st_reg.freq_b;
	assign ctr_wr[0]   = WR && sel.phase_a;
	assign ctr_wr[1]   = WR && sel.phase_b;

	// Both counters are the same pair of modules, differing only in wiring.
	for (genvar i = 0; i < 2; i++) begin : g_ctr
		logic [1:0] pin_sync;

		// The pins are asynchronous, so only the second flop is read.
		clpr_pin_sync u_sync (
			.REF_CLK  (REF_CLK),
			.RST_B    (RST_B),
			.PIN_IN   (ctr_pins[i]),
			.PIN_SYNC (pin_sync)
		);

		clpr_phase_ctr u_ctr (
			.REF_CLK (REF_CLK),
			.RST_B   (RST_B),
			.MODE    (ctr_mode[i]),
			.FREQ    (ctr_freq[i]),
			.PRI_PIN (pin_sync[0]),
			.SEC_PIN (pin_sync[1]),
			.WR_EN   (ctr_wr[i]),
			.WR_DATA (WDATA),
			.PHASE   (ctr_phase[i])
		);
	end

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		st_next       = st_reg;
		st_next.rdata = 32'h00000000;
		if (LAUNCH) begin
			st_next.launch_arg = LAUNCH_PARAM & `CLPR_LAUNCH_KEEP;
		end
		// Bus writes never reach the launch argument; it has no write arm.
		if (WR) begin
			if (sel.freq_a) begin
				st_next.freq_a = WDATA;
			end else if (sel.freq_b) begin
				st_next.freq_b = WDATA;
			end else if (sel.mode_a) begin
				st_next.mode_a = WDATA[`CLPR_MODE_W-1:0];
			end else if (sel.mode_b) begin
				st_next.mode_b = WDATA[`CLPR_MODE_W-1:0];
			end
		end
		if (RD) begin
			if (sel.launch_arg) begin
				st_next.rdata = {16'h0000, st_reg.launch_arg};
			end else if (sel.phase_a) begin
				st_next.rdata = ctr_phase[0];
			end else if (sel.phase_b) begin
				st_next.rdata = ctr_phase[1];
			end else if (sel.freq_a) begin
				st_next.rdata = st_reg.freq_a;
			end else if (sel.freq_b) begin
				st_next.rdata = st_reg.freq_b;
			end else if (sel.mode_a) begin
				st_next.rdata = {29'h0, st_reg.mode_a};
			end else if (sel.mode_b) begin
				st_next.rdata = {29'h0, st_reg.mode_b};
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign RDATA = st_reg.rdata;

endmodule : clpr_core_regs

// ==== test/clpr_core_regs_chk.sv ====
// Port-level assertions for the launch-argument and phase register bank.
module clpr_core_regs_chk
	import clpr_pkg::*;
(
	input wire logic        REF_CLK,
	input wire logic        RST_B,
	input wire logic [3:0]  ADDR,
	input wire logic [31:0] WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [31:0] RDATA,
	input wire logic        LAUNCH,
	input wire logic [15:0] LAUNCH_PARAM,
	input wire logic [1:0]  PIN_A,
	input wire logic [1:0]  PIN_B
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////////////////////////////////////
	a_read_idle_zero: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property ($past(RD) && $past(ADDR) > 4'h6
		|-> RDATA == 32'h0) else $error("unmapped read not zero");
	a_arg_low_clear: assert property ($past(RD) && $past(ADDR) == 4'h0
		|-> RDATA[1:0] == 2'h0 && RDATA[31:16] == 16'h0)
		else $error("launch argument exceeds its field");
	a_launch_loads: assert property (LAUNCH ##1 (RD && ADDR == 4'h0)
		|=> RDATA == {16'h0, $past(LAUNCH_PARAM, 2) & 16'hFFFC})
		else $error("launch argument not loaded");
	a_arg_read_only: assert property ((RD && ADDR == 4'h0 && !LAUNCH)
		##1 !LAUNCH [*3] ##1 (RD && ADDR == 4'h0) |=> RDATA == $past(RDATA, 4))
		else $error("launch argument changed without launch");
	// Hold modes must return exactly the value written between mode writes.
	a_hold_keeps: assert property ((WR && ADDR == 4'h5 && WDATA[2:0] inside
		{3'h0, 3'h7}) ##2 (WR && ADDR == 4'h1) ##2 (WR && ADDR == 4'h5)
		##2 (RD && ADDR == 4'h1) |=> RDATA == $past(WDATA, 5))
		else $error("phase moved in hold mode");
	a_accum_a: assert property ((WR && ADDR == 4'h3) ##2 (WR && ADDR == 4'h5
		&& WDATA[2:0] == 3'h1) ##2 (WR && ADDR == 4'h1) ##2 (WR && ADDR == 4'h5)
		##2 (RD && ADDR == 4'h1) |=> RDATA == $past(WDATA, 5)
		+ 32'h2 * $past(WDATA, 9)) else $error("phase A accumulation wrong");
	a_accum_b: assert property ((WR && ADDR == 4'h4) ##2 (WR && ADDR == 4'h6
		&& WDATA[2:0] == 3'h1) ##2 (WR && ADDR == 4'h2) ##2 (WR && ADDR == 4'h6)
		##2 (RD && ADDR == 4'h2) |=> RDATA == $past(WDATA, 5)
		+ 32'h2 * $past(WDATA, 9)) else $error("phase B accumulation wrong");
endmodule : clpr_core_regs_chk

// ==== test/clpr_core_regs_bench.sv ====
// Self-checking bench for the launch-argument and phase register bank.
module clpr_core_regs_bench
	import clpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        REF_CLK = 1'b0, RST_B = 1'b0, WR = 1'b0, RD = 1'b0;
	logic        LAUNCH = 1'b0;
	logic [3:0]  ADDR = 4'h0;
	logic [31:0] WDATA = 32'h0;
	logic [31:0] RDATA;
	logic [15:0] LAUNCH_PARAM = 16'h0;
	// Pins sit at primary high, secondary low so each mode has a fixed rate.
	logic [1:0]  PIN_A = 2'h1, PIN_B = 2'h1;
	int          n_errors = 0, check_count = 0, cyc = 0;

	clpr_core_regs dut (.REF_CLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.LAUNCH, .LAUNCH_PARAM, .PIN_A, .PIN_B);

	initial forever #2.5 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_errors = n_errors + 1;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(logic [3:0] a, logic [31:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge REF_CLK);
		WR <= 1'b0;
		@(posedge REF_CLK);
	endtask : wr

	task automatic rd(logic [3:0] a, logic [31:0] exp, string what);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge REF_CLK);
		RD <= 1'b0;
		#1 check(what, RDATA, exp);
		@(posedge REF_CLK);
	endtask : rd

	task automatic go(logic [15:0] p);
		LAUNCH_PARAM <= p;
		LAUNCH <= 1'b1;
		@(posedge REF_CLK);
		LAUNCH <= 1'b0;
	endtask : go

	task automatic drive_pins(int c, logic [1:0] v, int n);
		if (c == 0) begin
			PIN_A <= v;
		end else begin
			PIN_B <= v;
		end
		repeat (n) @(posedge REF_CLK);
	endtask : drive_pins
	////////////////////////////////////////////////////////////////////////
	task automatic test_launch();
		rd(4'h0, 32'h0, "launch arg reset");
		go(16'hFFFF);
		rd(4'h0, 32'h0000FFFC, "launch arg");
		wr(4'h0, 32'h00001234);
		rd(4'h0, 32'h0000FFFC, "launch arg after write");
		go(16'h1235);
		rd(4'h0, 32'h00001234, "launch arg relaunch");
		wr(4'hB, 32'h12345678);
		rd(4'hB, 32'h0, "unmapped");
		$display("test_launch done");
	endtask : test_launch

	// The phase write lands while the mode still accumulates, so it must win.
	task automatic test_modes();
		logic [31:0] rate;
		for (int c = 0; c < 2; c++) begin
			for (int m = 0; m < 8; m++) begin
				rate = (m == 1 || m == 2 || m == 6) ? 32'h1 : 32'h0;
				wr(4'h3 + c[3:0], 32'h1);
				wr(4'h5 + c[3:0], {29'h0, m[2:0]});
				wr(4'h1 + c[3:0], 32'hFFFFFFFF);
				wr(4'h5 + c[3:0], 32'h0);
				rd(4'h1 + c[3:0], 32'hFFFFFFFF + 2 * rate, "phase");
			end
		end
		$display("test_modes done");
	endtask : test_modes

	// Edge modes and the AND pair mode: the pins lag two flops inside the block.
	task automatic test_pins();
		logic [31:0] want;
		for (int c = 0; c < 2; c++) begin
			for (int m = 3; m < 6; m++) begin
				want = (m == 5) ? 32'h4 : 32'h3;
				wr(4'h1 + c[3:0], 32'h0);
				wr(4'h5 + c[3:0], {29'h0, m[2:0]});
				if (m == 5) begin
					drive_pins(c, 2'h3, 4);
				end else begin
					repeat (3) begin
						drive_pins(c, 2'h0, 2);
						drive_pins(c, 2'h1, 2);
					end
				end
				drive_pins(c, 2'h1, 4);
				wr(4'h5 + c[3:0], 32'h0);
				rd(4'h1 + c[3:0], want, "pin paced phase");
				// The update is a separate read and write, never one step.
				wr(4'h1 + c[3:0], want + 32'h5);
				rd(4'h1 + c[3:0], want + 32'h5, "phase rewritten");
			end
		end
		$display("test_pins done");
	endtask : test_pins

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (6) @(posedge REF_CLK);
		RST_B <= 1'b1;
		@(posedge REF_CLK);
		test_launch();
		test_modes();
		test_pins();
		tally_and_finish();
	end
endmodule : clpr_core_regs_bench

bind clpr_core_regs clpr_core_regs_chk chk (.REF_CLK, .RST_B, .ADDR, .WDATA,
	.WR, .RD, .RDATA, .LAUNCH, .LAUNCH_PARAM, .PIN_A, .PIN_B);
